// File: bdspi_pkg.sv
// Purpose: shared constants and types of the bridge driver serial slave
// Assumes: 16-bit frames, chip address in the two top bits
// Notes:   frame offsets, config field positions and the cfg, diag and lock reset values live here

package bdspi_pkg;

	// ****************************************************************
	// frame layout
	// ****************************************************************
	localparam int         FRAME_BITS    = 16;
	localparam int         CNT_W         = 5;
	localparam logic [4:0] CNT_ADDR_LAST = 5'h01;  // fall that ends address
	localparam logic [4:0] CNT_CMD_LAST  = 5'h07;  // fall that ends command
	localparam logic [4:0] CNT_FIRST_OUT = 5'h02;  // first driven bit count
	localparam logic [4:0] CNT_FRAME     = 5'h10;  // exact clocks per frame
	localparam logic [4:0] CNT_MAX       = 5'h1f;  // counter saturates here
	localparam logic [3:0] TX_TOP        = 4'hf;
	localparam logic [1:0] CHIP_ADDR     = 2'h0;
	localparam logic [4:0] VERIFY_PAT    = 5'h15;  // 1 0 1 0 1

	// ****************************************************************
	// command codes
	// ****************************************************************
	localparam logic [5:0] CMD_WR_CFG  = 6'h33;
	localparam logic [5:0] CMD_READ_IDENTITY_CMD   = 6'h00;
	localparam logic [5:0] CMD_READ_REVISION_CMD  = 6'h03;
	localparam logic [5:0] CMD_RD_CFG  = 6'h28;
	localparam logic [5:0] CMD_RD_DIAG = 6'h09;

	// ****************************************************************
	// register fields and reset values
	// ****************************************************************
	localparam int         CFG_SF_BIT    = 7;
	localparam int         CFG_PUMP_BIT  = 6;
	localparam int         CFG_OUT2_BIT  = 5;
	localparam int         CFG_OUT1_BIT  = 4;
	localparam int         CFG_LIM_HI    = 3;
	localparam int         CFG_LIM_LO    = 2;
	localparam logic [7:0] CFG_WR_MASK   = 8'hfc;  // b1..b0 reserved
	localparam logic [7:0] CFG_RESET     = 8'h38;
	localparam logic [7:0] DIAG_RESET    = 8'hf0;
	localparam logic [7:0] DIAG_CLEAR    = 8'hff;  // all fields normal
	localparam logic       LOCK_RESET    = 1'b1;
	localparam logic [7:0] RESP_NONE     = 8'h00;

	// frame tracking states
	typedef enum logic [1:0] {
		FS_IDLE = 2'b00,
		FS_ADDR = 2'b01,
		FS_RESP = 2'b10,
		FS_SKIP = 2'b11
	} bdspi_frame_e;

endpackage

// File: bdspi_pin_if.sv
// Purpose: carries synchronised serial pins and their edges to the core
// Assumes: all signals are on core_clk_i
// Notes:   edge flags are one-cycle pulses

`timescale 1ns/1ps

interface bdspi_pin_if;
	logic cs_n;
	logic si;
	logic en;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;

	modport sync (output cs_n, si, en, cs_fall, cs_rise, sclk_rise,
		sclk_fall);
	modport core (input cs_n, si, en, cs_fall, cs_rise, sclk_rise,
		sclk_fall);
endinterface

// File: bdspi_pin_sync.sv
// Purpose: brings the serial pins and enable pin into the core clock
// Assumes: pins toggle far slower than core_clk_i
// Notes:   two flops per pin, a third stage only for edge finding

`timescale 1ns/1ps

module bdspi_pin_sync
	import bdspi_pkg::*;
(
	input  logic         core_clk_i,
	input  logic         rst_i,
	input  logic         sclk_i,
	input  logic         chip_select_n_i,
	input  logic         si_i,
	input  logic         enable_pin_i,
	bdspi_pin_if.sync    p
);

	// ****************************************************************
	// synchroniser stages
	// ****************************************************************
	logic [3:0] raw;
	logic [3:0] meta;
	logic [3:0] stab;
	logic [3:0] prev;

	assign raw = {enable_pin_i, si_i, chip_select_n_i, sclk_i};

	// idle levels: deselected, clock low; first stage feeds only the second
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meta <= 4'h2;
			stab <= 4'h2;
			prev <= 4'h2;
		end else begin
			meta <= raw;
			stab <= meta;
			prev <= stab;
		end
	end

	// edges come from settled stages only
	assign p.sclk_rise = stab[0] & ~prev[0];
	assign p.sclk_fall = ~stab[0] & prev[0];
	assign p.cs_fall   = ~stab[1] & prev[1];
	assign p.cs_rise   = stab[1] & ~prev[1];
	assign p.cs_n      = stab[1];
	assign p.si        = stab[2];
	assign p.en        = stab[3];

endmodule

// File: bdspi_top.sv
// Purpose: 16-bit serial command slave of a motor bridge driver
// Assumes: sclk_i idles low, data out on rising, data in on falling
// Notes:   pins are oversampled by core_clk_i; fault logic lives outside
//
// How it works
// (R1) Slave only; master drives select, every clock edge and data in.
// (R2) Serial output stays undriven while select is high.
// (R3) Top two frame bits are chip address; only 00 answers.
// (R4) Output undriven until address decoded; mismatch ignores whole frame.
// (R5) Sixteen bits in, fourteen bits out, most significant bit first.
// (R6) Reply shifts out in the same frame right after address and command.
// (R7) Commit at select rise needs address match, 16 clocks, known command.
// (R8) Wrong clock count or unknown command sets transfer error flag.
// (R9) Next fully valid frame clears the transfer error flag.
// (R10) Errored frame leaves configuration and diagnostic registers untouched.
// (R11) With address matched, output changes on each rising serial clock.
// (R12) Serial input is sampled on each falling serial clock.
// (R13) Out: two undriven bits, 10101, error flag, eight data bits.
// (R14) Five command codes decode; any other with matched address invalid.
// (R15) Configuration bits: flag mode, pump mode, two enables, limit select.
// (R16) Configuration write replies with diagnostics and keeps them.
// (R17) Diagnostic read replies with diagnostics then clears latched data.
// (R18) Configuration write only accepted while enable pin is low.
// (R19) Identity and revision reads return fixed hard-wired bytes.
// (R20) Fault lockout sets lock bit four of configuration readback.
// (R21) Diagnostic register holds f0 after power-up.
// (R22) Diagnostic clear happens at select rise, valid frames only.
// (R23) Counter and shift state clear at every select fall.

`timescale 1ns/1ps

module bdspi_top
	import bdspi_pkg::*;
#(
	parameter logic [7:0] ID_CODE  = 8'h5a,  // arbitrary identity value
	parameter logic [7:0] REV_CODE = 8'h23   // arbitrary revision value
) (
	input  logic         core_clk_i,
	input  logic         rst_i,
	input  logic         sclk_i,
	input  logic         chip_select_n_i,
	input  logic         si_i,
	input  logic         enable_pin_i,
	input  logic         lock_set_i,
	input  logic         lock_clear_i,
	input  logic         diag_load_i,
	input  logic [7:0]   diag_data_i,
	input  logic [1:0]   spare_status_i,
	output logic         so_o,
	output logic         so_oe_o,
	output logic [7:0]   cfg_o,
	output logic [7:0]   diag_o,
	output logic         lock_o,
	output logic         transfer_error_flag_o
);

	// ****************************************************************
	// pin synchronisation
	// ****************************************************************
	bdspi_pin_if p ();

	// (R1) slave timing
	// every edge we act on is one the master made
	bdspi_pin_sync u_sync (
		.core_clk_i      (core_clk_i),
		.rst_i           (rst_i),
		.sclk_i          (sclk_i),
		.chip_select_n_i (chip_select_n_i),
		.si_i            (si_i),
		.enable_pin_i    (enable_pin_i),
		.p               (p)
	);

	// ****************************************************************
	// state
	// ****************************************************************
	bdspi_frame_e state;
	bdspi_frame_e next_state;
	logic [4:0]   bit_cnt;
	logic [15:0]  shift;
	logic [5:0]   cmd;
	logic [7:0]   resp_byte;
	logic [7:0]   cfg;
	logic [7:0]   diag;
	logic         lock;
	logic         tf;

	// (R14) command decode
	// used only for frame validity; the reply byte comes from resp_sel
	function automatic logic cmd_known(input logic [5:0] c);
		cmd_known = (c == CMD_WR_CFG) || (c == CMD_READ_IDENTITY_CMD) ||
			(c == CMD_READ_REVISION_CMD) || (c == CMD_RD_CFG) ||
			(c == CMD_RD_DIAG);
	endfunction

	// (R16) reply byte per command
	function automatic logic [7:0] resp_sel(input logic [5:0] c,
		input logic [7:0] rb, input logic [7:0] dg);
		case (c)
			CMD_WR_CFG:  resp_sel = dg;
			CMD_RD_DIAG: resp_sel = dg;
			CMD_RD_CFG:  resp_sel = rb;
			// (R19) fixed bytes
			CMD_READ_IDENTITY_CMD:   resp_sel = ID_CODE;
			CMD_READ_REVISION_CMD:  resp_sel = REV_CODE;
			default:     resp_sel = RESP_NONE;
		endcase
	endfunction

	// ****************************************************************
	// decode wires
	// ****************************************************************
	logic        in_frame;
	logic        sample;
	logic [1:0]  addr_bits;
	logic [5:0]  cmd_bits;
	logic        frame_ok;
	logic        frame_end;
	logic        do_write;
	logic        do_diag_clr;
	logic [7:0]  cfg_rb;
	logic [15:0] tx_word;
	logic [3:0]  tx_idx;
	logic        next_so;

	assign in_frame  = (state != FS_IDLE) && !p.cs_n;
	// (R12) sample on falling serial clock
	assign sample    = in_frame && p.sclk_fall;
	assign addr_bits = {shift[0], p.si};
	assign cmd_bits  = {shift[4:0], p.si};
	assign frame_end = p.cs_rise && (state == FS_RESP);

	// (R7) all three checks
	assign frame_ok  = (state == FS_RESP) && (bit_cnt == CNT_FRAME) &&
		cmd_known(cmd);

	// (R18) enable pin gates writes
	assign do_write    = frame_end && frame_ok && (cmd == CMD_WR_CFG) &&
		!p.en;
	// (R22) clear only on valid frame end
	assign do_diag_clr = frame_end && frame_ok && (cmd == CMD_RD_DIAG);

	// (R20) lock bit in readback
	// both-enabled status is derived from the two enable bits
	assign cfg_rb = {cfg[CFG_SF_BIT], cfg[CFG_PUMP_BIT],
		cfg[CFG_OUT2_BIT] & cfg[CFG_OUT1_BIT], lock,
		cfg[CFG_LIM_HI], cfg[CFG_LIM_LO], spare_status_i};

	// (R13) outgoing word layout
	// (R5) msb first by counting the index down
	assign tx_word = {CHIP_ADDR, VERIFY_PAT, tf, resp_byte};
	assign tx_idx  = TX_TOP - bit_cnt[3:0];
	assign next_so = (bit_cnt < CNT_FRAME) ? tx_word[tx_idx] : 1'b0;

	// ****************************************************************
	// frame state machine
	// ****************************************************************
	// a select fall restarts tracking whatever came before
	always_comb begin
		next_state = state;
		if (p.cs_fall) begin
			next_state = FS_ADDR;
		end else begin
			case (state)
				FS_IDLE: begin
					next_state = FS_IDLE;
				end
				FS_ADDR: begin
					if (p.cs_rise) begin
						next_state = FS_IDLE;
					// (R3) address match
					end else if (sample && bit_cnt == CNT_ADDR_LAST) begin
						next_state = (addr_bits == CHIP_ADDR) ? FS_RESP :
							FS_SKIP;
					end
				end
				FS_RESP, FS_SKIP: begin
					if (p.cs_rise) begin
						next_state = FS_IDLE;
					end
				end
				default: begin
					next_state = FS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state <= FS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// receive path
	// ****************************************************************
	// (R23) fresh count per frame
	// saturates so a runaway clock never wraps back to sixteen
	always_ff @(posedge core_clk_i) begin
		if (rst_i || p.cs_fall) begin
			bit_cnt <= 5'h00;
			shift   <= 16'h0000;
		end else if (sample) begin
			bit_cnt <= (bit_cnt == CNT_MAX) ? CNT_MAX : bit_cnt + 5'h01;
			shift   <= {shift[14:0], p.si};
		end
	end

	// (R6) reply chosen once the command is in
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cmd       <= CMD_READ_IDENTITY_CMD;
			resp_byte <= RESP_NONE;
		end else if (sample && bit_cnt == CNT_CMD_LAST &&
			state == FS_RESP) begin
			cmd       <= cmd_bits;
			resp_byte <= resp_sel(cmd_bits, cfg_rb, diag);
		end
	end

	// ****************************************************************
	// transmit path
	// ****************************************************************
	// (R2) (R4) (R11) drive only in a matched frame
	// the enable drops on the synced select rise, in the same cycle the state leaves FS_RESP
	always_ff @(posedge core_clk_i) begin
		if (rst_i || p.cs_rise || state != FS_RESP) begin
			so_o    <= 1'b0;
			so_oe_o <= 1'b0;
		end else if (p.sclk_rise && bit_cnt >= CNT_FIRST_OUT) begin
			so_o    <= next_so;
			so_oe_o <= 1'b1;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	// (R8) (R9) flag follows the last matched frame
	// mismatched frames never touch it
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tf <= 1'b0;
		end else if (frame_end) begin
			tf <= !frame_ok;
		end
	end

	// (R15) (R10) configuration commit
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cfg <= CFG_RESET;
		end else if (do_write) begin
			cfg <= shift[7:0] & CFG_WR_MASK;
		end
	end

	// (R17) (R21) diagnostic latch and clear; a new fault beats the clear
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			diag <= DIAG_RESET;
		end else if (diag_load_i) begin
			diag <= diag_data_i;
		end else if (do_diag_clr) begin
			diag <= DIAG_CLEAR;
		end
	end

	// (R20) lockout entry sets, release clears; set wins
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			lock <= LOCK_RESET;
		end else if (lock_set_i) begin
			lock <= 1'b1;
		end else if (lock_clear_i) begin
			lock <= 1'b0;
		end
	end

	assign cfg_o                 = cfg;
	assign diag_o                = diag;
	assign lock_o                = lock;
	assign transfer_error_flag_o = tf;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	a_so_off_desel: assert property ( // R2
		p.cs_rise |=> !so_oe_o [*2])
		else $error("output driven after deselect");
	a_so_needs_addr: assert property ( // R4
		so_oe_o |-> state == FS_RESP)
		else $error("output driven without address match");
	a_so_rise_drive: assert property ( // R11
		p.sclk_rise && state == FS_RESP && !p.cs_rise &&
		bit_cnt == CNT_FIRST_OUT |=> so_oe_o && so_o)
		else $error("first reply bit not 1 on rising edge");
	a_tf_set_err: assert property ( // R8
		frame_end && bit_cnt != CNT_FRAME |=> tf)
		else $error("bad clock count did not set flag");
	a_tf_clear_ok: assert property ( // R9
		frame_end && frame_ok |=> !tf)
		else $error("valid frame did not clear flag");
	a_cfg_hold_err: assert property ( // R10
		p.cs_rise && !frame_ok |=> $stable(cfg))
		else $error("config changed on bad frame");
	a_cfg_en_block: assert property ( // R18
		p.en |=> $stable(cfg))
		else $error("config changed with enable high");
	a_cfg_commit: assert property ( // R7
		frame_end && frame_ok && cmd == CMD_WR_CFG && !p.en
		|=> cfg == ($past(shift[7:0]) & CFG_WR_MASK))
		else $error("valid write not committed");
	a_diag_clear: assert property ( // R22
		do_diag_clr && !diag_load_i |=> diag == DIAG_CLEAR)
		else $error("diag not cleared after valid read");
	a_cnt_restart: assert property ( // R23
		p.cs_fall |=> bit_cnt == 5'h00 && state == FS_ADDR)
		else $error("frame state not restarted");

	c_valid_write: cover property (do_write);
	c_diag_read:   cover property (do_diag_clr);
	c_bad_count:   cover property (frame_end && bit_cnt != CNT_FRAME);
	c_addr_skip:   cover property (p.cs_rise && state == FS_SKIP);

endmodule

// File: bdspi_master.sv
// Purpose: behavioural serial master that stands in for the controller
// Assumes: clock idles low, 64 ns bit period, device answers on rising
// Notes:   reply is sampled just before the next rise, after so settles

`timescale 1ns/1ps

module bdspi_master (
	output logic      sclk_o,
	output logic      chip_select_n_o,
	output logic      si_o,
	input  wire logic so_i
);
	localparam int HALF = 32;

	// idle link: select high, clock low
	initial begin
		sclk_o = 1'b0;
		chip_select_n_o = 1'b1;
		si_o = 1'b1;
	end

	// master drives select, clocks and msb first data
	task automatic xfer(input logic [15:0] word, input int nclk,
		output logic [15:0] got);
		got = 16'hxxxx;
		chip_select_n_o = 1'b0;
		#HALF;
		for (int i = 0; i < nclk; i++) begin
			sclk_o = 1'b1;
			si_o = (i < 16) ? word[15 - i] : 1'b0;
			#HALF;
			sclk_o = 1'b0;
			// late sample: the device output lags the pin by some cycles
			#(HALF - 2);
			if (i < 16) got[15 - i] = so_i;
			#2;
		end
		chip_select_n_o = 1'b1;
		// released line shows the inverse so a stale value cannot pass
		si_o = ~si_o;
	endtask
endmodule

// File: test_bridge_driver_spi_slave.sv
// Purpose: self-checking bench of the serial command slave
// Assumes: master model on the pins, fault inputs driven by the bench
// Notes:   expected replies are built from the frame layout constants

`timescale 1ns/1ps

module test_bridge_driver_spi_slave;
	import bdspi_pkg::*;
	localparam logic [7:0] ID_V  = 8'h3c;  // arbitrary identity value
	localparam logic [7:0] REV_V = 8'h41;  // arbitrary revision value
	logic       core_clk_i, rst_i, sclk, cs_n, si, en_pin;
	logic       lk_set, lk_clr, dg_ld, so_o, so_oe_o, lock_o, tef_o;
	logic [7:0] dg_data, cfg_o, diag_o;
	logic [1:0] spare;
	logic       exp_flag;
	wire        so_w;
	int         failures, samples_checked, cycles;

	// ****************************************************************
	// design, master and pin resolution
	// ****************************************************************
	assign so_w = so_oe_o ? so_o : 1'bz;

	bdspi_top #(.ID_CODE(ID_V), .REV_CODE(REV_V)) dut_u (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk),
		.chip_select_n_i(cs_n), .si_i(si), .enable_pin_i(en_pin),
		.lock_set_i(lk_set), .lock_clear_i(lk_clr), .diag_load_i(dg_ld),
		.diag_data_i(dg_data), .spare_status_i(spare), .so_o(so_o),
		.so_oe_o(so_oe_o), .cfg_o(cfg_o), .diag_o(diag_o),
		.lock_o(lock_o), .transfer_error_flag_o(tef_o));

	bdspi_master master_u (.sclk_o(sclk), .chip_select_n_o(cs_n),
		.si_o(si), .so_i(so_w));

	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	// hang guard: the whole run needs some 2300 cycles
	initial cycles = 0;
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			failures++;
			final_report();
		end
	end

	// ****************************************************************
	// checking tasks
	// ****************************************************************
	task automatic final_report();
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask

	function automatic logic known(input logic [5:0] c);
		return c == CMD_WR_CFG || c == CMD_READ_IDENTITY_CMD || c == CMD_READ_REVISION_CMD ||
			c == CMD_RD_CFG || c == CMD_RD_DIAG;
	endfunction

	// mode 0 compares the reply, 1 expects silence, 2 skips the reply
	task automatic frame(input logic [15:0] w, input int n,
		input logic [7:0] d, input int mode);
		logic [15:0] got;
		logic [15:0] exp;
		exp = {2'bzz, VERIFY_PAT, exp_flag, d};
		master_u.xfer(w, n, got);
		repeat (8) @(posedge core_clk_i);
		#1;
		if (mode == 0) chk(got, exp);
		if (mode == 1) chk(got, 16'hzzzz);
		if (w[15:14] == CHIP_ADDR && n >= 2)
			exp_flag = !((n == 16) && known(w[13:8]));
		chk({15'h0, tef_o}, {15'h0, exp_flag});
	endtask

	task automatic pulse(input int which);
		@(posedge core_clk_i);
		#1;
		{dg_ld, lk_clr, lk_set} = 3'b001 << which;
		@(posedge core_clk_i);
		#1;
		{dg_ld, lk_clr, lk_set} = 3'b000;
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		failures = 0;
		samples_checked = 0;
		exp_flag = 1'b0;
		rst_i = 1'b1;
		en_pin = 1'b0;
		{dg_ld, lk_clr, lk_set} = 3'b000;
		dg_data = 8'h5a;
		spare = 2'b10;
		repeat (4) @(posedge core_clk_i);
		#1;
		rst_i = 1'b0;
		repeat (8) @(posedge core_clk_i);
		#1;
		chk({8'h0, cfg_o}, {8'h0, CFG_RESET});
		chk({8'h0, diag_o}, 16'h00f0);
		chk({14'h0, lock_o, so_oe_o}, 16'h0002);
		frame({CHIP_ADDR, CMD_READ_IDENTITY_CMD, 8'h00}, 16, ID_V, 0);
		frame({CHIP_ADDR, CMD_READ_REVISION_CMD, 8'hff}, 16, REV_V, 0);
		frame({CHIP_ADDR, CMD_RD_CFG, 8'h00}, 16, 8'h3a, 0);
		frame({CHIP_ADDR, CMD_RD_DIAG, 8'h00}, 16, 8'hf0, 0);
		chk({8'h0, diag_o}, 16'h00ff);
		frame({CHIP_ADDR, CMD_WR_CFG, 8'hcf}, 16, 8'hff, 0);
		chk({cfg_o, diag_o}, 16'hccff);
		pulse(2);
		frame({CHIP_ADDR, CMD_WR_CFG, 8'h30}, 16, 8'h5a, 0);
		chk({cfg_o, diag_o}, 16'h305a);
		for (int a = 1; a < 4; a++)
			frame({a[1:0], CMD_WR_CFG, 8'hcc}, 16, 8'h00, 1);
		frame({CHIP_ADDR, CMD_WR_CFG, 8'hcc}, 15, 8'h00, 2);
		frame({CHIP_ADDR, CMD_RD_DIAG, 8'h00}, 17, 8'h00, 2);
		chk({cfg_o, diag_o}, 16'h305a);
		frame({CHIP_ADDR, 6'h3f, 8'h00}, 16, RESP_NONE, 0);
		frame({CHIP_ADDR, CMD_RD_DIAG, 8'h00}, 16, 8'h5a, 0);
		chk({cfg_o, diag_o}, 16'h30ff);
		en_pin = 1'b1;
		frame({CHIP_ADDR, CMD_WR_CFG, 8'hc0}, 16, 8'hff, 0);
		chk({8'h0, cfg_o}, 16'h0030);
		en_pin = 1'b0;
		pulse(1);
		frame({CHIP_ADDR, CMD_RD_CFG, 8'h00}, 16, 8'h22, 0);
		pulse(0);
		frame({CHIP_ADDR, CMD_RD_CFG, 8'h00}, 16, 8'h32, 0);
		final_report();
	end
endmodule
